// [tpwm_consts.vh]
// Register map, field positions, reset values and codes of the two-channel PWM timer
`ifndef TPWM_CONSTS_VH
`define TPWM_CONSTS_VH

// APB byte addresses, one aligned word per register
`define TPWM_ADDR_STATUS_CONTROL 8'h00
`define TPWM_ADDR_COUNTER        8'h04
`define TPWM_ADDR_MODULO         8'h08
`define TPWM_ADDR_CH0_CONTROL    8'h0C
`define TPWM_ADDR_CH0_VALUE      8'h10
`define TPWM_ADDR_CH1_CONTROL    8'h14
`define TPWM_ADDR_CH1_VALUE      8'h18

// Status/control register fields
`define TPWM_SC_OVF_FLAG   7
`define TPWM_SC_OVF_IE     6
`define TPWM_SC_HALT       5
`define TPWM_SC_CLEAR      4
`define TPWM_SC_DIV_HI     2
`define TPWM_SC_DIV_LO     0

// Channel control register fields
`define TPWM_CH_FLAG       7
`define TPWM_CH_IE         6
`define TPWM_CH_LINK       5
`define TPWM_CH_MODE       4
`define TPWM_CH_ELS_HIGH   3
`define TPWM_CH_ELS_LOW    2
`define TPWM_CH_TOGGLE     1
`define TPWM_CH_MAX        0

// Reset values
`define TPWM_RST_HALT      1'b1
`define TPWM_RST_DIV       3'h0
`define TPWM_RST_MODULO    16'hFFFF
`define TPWM_RST_VALUE     16'h0000
`define TPWM_RST_CTRL      7'h00

// Prescaler code that delivers no counter clock
`define TPWM_DIV_NONE      3'h7

// Edge/level codes
`define TPWM_ELS_OFF       2'h0
`define TPWM_ELS_TOGGLE    2'h1
`define TPWM_ELS_CLEAR     2'h2
`define TPWM_ELS_SET       2'h3

`endif

// [tpwm_channel.v]
// One timer channel: capture/compare/PWM pin logic and its two-step cleared flag
`include "tpwm_consts.vh"

module tpwm_channel #(
  parameter WIDTH = 16
) (
  input  wire             sysClk,
  input  wire             rstN,
  input  wire             tick,          // Counter clock enable
  input  wire             overflowEvt,   // Counter wrap, same cycle as tick
  input  wire [WIDTH-1:0] counter,       // Current counter value
  input  wire [WIDTH-1:0] compareValue,  // Active compare value
  input  wire             enable,        // Channel owns its pin
  input  wire             compareMode,   // Output compare or PWM selected
  input  wire [1:0]       edgeLevelSel,  // Edge or level select pair
  input  wire             toggleEn,      // Toggle on overflow
  input  wire             fullDutyEn,    // Constant full duty
  input  wire             pinSync,       // Synchronised pin level
  input  wire             captureAllow,  // Counter running, no break
  input  wire             flagReadArm,   // Control register read
  input  wire             flagWriteZero, // Control register write with flag bit 0
  input  wire             flagProtect,   // Status bits frozen
  output reg              flag,          // Capture or compare seen
  output reg              pinOut,        // Pin output level
  output wire             pinOe,         // Pin driven by the timer
  output wire             captureStrobe  // Take the counter into the value
);

  reg  pinLast;   // Pin level one cycle ago
  reg  armed;     // First clear step done
  wire active;    // Channel connected to pin
  wire isCapture; // Input capture mode
  wire rise;      // Rising edge on pin
  wire fall;      // Falling edge on pin
  wire matchEvt;  // Output compare event
  wire evt;       // Any flag setting event
  wire fullLevel; // Level held at full duty

  assign active    = enable && (edgeLevelSel != `TPWM_ELS_OFF);
  assign isCapture = active && !compareMode;
  assign rise      = pinSync && !pinLast;
  assign fall      = !pinSync && pinLast;

  // Capture on selected edges, only while the counter may run
  assign captureStrobe = isCapture && captureAllow &&
                         ((edgeLevelSel[0] && rise) || (edgeLevelSel[1] && fall));
  assign matchEvt = active && compareMode && tick && (counter == compareValue);
  assign evt      = captureStrobe || matchEvt;

  // Full duty sits at the pulse level, the complement of the set-on-compare level
  assign fullLevel = (edgeLevelSel == `TPWM_ELS_SET) ? 1'b0 : 1'b1;
  assign pinOe     = active && compareMode;

  // Pin history for edge detection
  always @(posedge sysClk) begin
    if (!rstN) begin
      pinLast <= 1'b0;
    end else begin
      pinLast <= pinSync;
    end
  end

  // Output level; overflow toggle first, compare action last wins
  always @(posedge sysClk) begin
    if (!rstN) begin
      pinOut <= 1'b1;
    end else if (!active) begin
      pinOut <= ~compareMode; // Preset level while pin is freed
    end else if (compareMode) begin
      if (fullDutyEn && toggleEn) begin
        pinOut <= fullLevel;
      end else if (matchEvt) begin
        case (edgeLevelSel)
          `TPWM_ELS_TOGGLE: pinOut <= (overflowEvt && toggleEn) ? pinOut : ~pinOut;
          `TPWM_ELS_CLEAR:  pinOut <= 1'b0;
          `TPWM_ELS_SET:    pinOut <= 1'b1;
          default:          pinOut <= pinOut;
        endcase
      end else if (overflowEvt && toggleEn) begin
        pinOut <= ~pinOut; // no toggle without toggleEn
      end
    end
  end

  // Flag: event wins over clear; frozen under protected break
  always @(posedge sysClk) begin
    if (!rstN) begin
      flag  <= 1'b0;
      armed <= 1'b0;
    end else if (evt) begin
      flag  <= 1'b1;
      armed <= 1'b0; // new event spoils the pending clear
    end else if (flagWriteZero && armed && !flagProtect) begin
      flag  <= 1'b0;
      armed <= 1'b0;
    end else if (flagReadArm && flag && !flagProtect) begin
      armed <= 1'b1;
    end
  end

endmodule // tpwm_channel

// [tpwm_timer.v]
// Two-channel 16-bit PWM timer with prescaler, linked buffered PWM and APB registers
//
// Notes on behaviour
// - Link bit pairs channels for channel0 output.
// - Last written value set takes over at overflow.
// - Linked: channel0 control governs, channel1 pin freed.
// - Link outranks compare mode select.
// - Without overflow toggle, output stays at 0%.
// - Full duty plus overflow toggle gives 100%.
// - Counter at modulo sets overflow flag, interrupt.
// - Capture or compare sets channel flag, interrupt.
// - Overflow flag cleared by read then zero-write.
// - Wait state: counting continues, registers blocked.
// - Break halts counter and blocks captures.
// - Break clear enable decides status bit changes.
// - Halt bit stops counter, set by reset.
// - Captures inhibited while halted.
// - Clear bit zeroes counter and prescaler, reads 0.
// - Halt plus clear leaves counter at zero.
// - Divide select picks bus clock divided 1..64.
// - Each pin capture or compare; channel0 buffered.
// - At modulo, overflow and restart from zero.
// - Edge codes toggle, clear, set; 00 frees pin.
// - Channel flag cleared by read then zero-write.
`include "tpwm_consts.vh"

module tpwm_timer #(
  parameter WIDTH = 16
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        waitMode,         // Processor in low-power wait
  input  wire        breakState,       // Processor in break
  input  wire        breakClearEnable, // Status bits may change in break
  input  wire        channel0PinIn,    // Channel 0 pin level
  input  wire        channel1PinIn,    // Channel 1 pin level
  output wire        channel0PinOut,   // Channel 0 drive level
  output wire        channel0PinOe,    // Channel 0 driven by timer
  output wire        channel1PinOut,   // Channel 1 drive level
  output wire        channel1PinOe,    // Channel 1 driven by timer
  output wire        timerIrq          // Interrupt and wake request
);

  // Status/control state
  reg              overflowFlag;     // Counter reached modulo
  reg              overflowArmed;    // First step of flag clear done
  reg              overflowIrqEn;    // Overflow interrupt enable
  reg              counterHalt;      // Counter stopped
  reg  [2:0]       clockDivideSel;   // Prescaler select

  // Counter and prescaler
  reg  [WIDTH-1:0] counter;          // Main counter
  reg  [WIDTH-1:0] modulo;           // Period end value
  reg  [5:0]       prescaler;        // Free divider for counter clock
  reg  [6:0]       divMask;          // Low prescaler bits that must be all ones

  // Channel registers
  reg  [6:0]       ch0Ctrl;          // Channel 0 control bits 6..0
  reg  [6:0]       ch1Ctrl;          // Channel 1 control bits 6..0
  reg  [WIDTH-1:0] ch0Value;         // Channel 0 compare/capture value
  reg  [WIDTH-1:0] ch1Value;         // Channel 1 compare/capture value
  reg              activeSet;        // Linked: which value set drives the pin
  reg              lastWritten;      // Linked: value set written most recently

  // Pin synchronisers
  reg  [1:0]       ch0Sync;          // Two stages, bit 1 is read
  reg  [1:0]       ch1Sync;          // Two stages, bit 1 is read

  // Bus decode
  wire             setupPhase;       // APB setup cycle
  wire             accessDone;       // APB access completes without error this edge
  wire             writeDone;        // Accepted write
  wire             readDone;         // Accepted read
  wire             addrMapped;       // Address names a register
  wire             flagProtect;      // Break without clear permission

  // Counting
  wire             runEn;            // Counter may run
  wire             tick;             // Counter clock enable
  wire             atModulo;         // Counter equals modulo
  wire             overflowEvt;      // Wrap on a tick
  wire             clearReq;         // Counter clear written

  // Channel wiring
  wire             linkOn;           // Channels paired
  wire [WIDTH-1:0] ch0Compare;       // Value set driving channel 0
  wire             ch0Flag;          // Channel 0 flag
  wire             ch1Flag;          // Channel 1 flag
  wire             ch0Capture;       // Channel 0 capture strobe
  wire             ch1Capture;       // Channel 1 capture strobe
  wire             ch0ReadArm;       // Channel 0 control read done
  wire             ch1ReadArm;       // Channel 1 control read done
  wire             ch0WriteZero;     // Channel 0 control write with flag 0
  wire             ch1WriteZero;     // Channel 1 control write with flag 0

  // Zero-wait slave: every access phase completes at once
  assign pready     = psel && penable;
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && !pslverr;
  assign writeDone  = accessDone && pwrite;
  assign readDone   = accessDone && !pwrite;

  // Mapped register addresses
  assign addrMapped = (paddr == `TPWM_ADDR_STATUS_CONTROL) || (paddr == `TPWM_ADDR_COUNTER) ||
                      (paddr == `TPWM_ADDR_MODULO)         || (paddr == `TPWM_ADDR_CH0_CONTROL) ||
                      (paddr == `TPWM_ADDR_CH0_VALUE)      || (paddr == `TPWM_ADDR_CH1_CONTROL) ||
                      (paddr == `TPWM_ADDR_CH1_VALUE);

  // Status bits frozen in break unless clearing is allowed
  assign flagProtect = breakState && !breakClearEnable;

  // Mask of prescaler bits per divide code
  always @* begin
    case (clockDivideSel)
      3'h0:    divMask = 7'h00;
      3'h1:    divMask = 7'h01;
      3'h2:    divMask = 7'h03;
      3'h3:    divMask = 7'h07;
      3'h4:    divMask = 7'h0F;
      3'h5:    divMask = 7'h1F;
      3'h6:    divMask = 7'h3F;
      default: divMask = 7'h7F; // never reached by a 6-bit prescaler
    endcase
  end

  // Counter runs in wait state too; only halt, break and divide code 7 stop it
  assign runEn       = !counterHalt && !breakState;
  assign tick        = runEn && (clockDivideSel != `TPWM_DIV_NONE) &&
                       (({1'b0, prescaler} & divMask) == divMask);
  assign atModulo    = (counter == modulo);
  assign overflowEvt = tick && atModulo;
  assign clearReq    = writeDone && (paddr == `TPWM_ADDR_STATUS_CONTROL) && pwdata[`TPWM_SC_CLEAR];

  // Prescaler: cleared by the clear bit, frozen while halted or in break
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      prescaler <= 6'h00;
    end else if (clearReq) begin
      prescaler <= 6'h00;
    end else if (runEn) begin
      prescaler <= prescaler + 6'h01;
    end
  end

  // Main counter; a clear write wins over a tick in the same cycle
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      counter <= {WIDTH{1'b0}};
    end else if (clearReq) begin
      counter <= {WIDTH{1'b0}};
    end else if (overflowEvt) begin
      counter <= {WIDTH{1'b0}};
    end else if (tick) begin
      counter <= counter + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Status/control register; clear bit is write-only, never stored
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      overflowIrqEn  <= 1'b0;
      counterHalt    <= `TPWM_RST_HALT;
      clockDivideSel <= `TPWM_RST_DIV;
    end else if (writeDone && (paddr == `TPWM_ADDR_STATUS_CONTROL)) begin
      overflowIrqEn  <= pwdata[`TPWM_SC_OVF_IE];
      counterHalt    <= pwdata[`TPWM_SC_HALT];
      clockDivideSel <= pwdata[`TPWM_SC_DIV_HI:`TPWM_SC_DIV_LO];
    end
  end

  // Overflow flag: set beats clear, two-step clear, frozen under protect
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      overflowFlag  <= 1'b0;
      overflowArmed <= 1'b0;
    end else if (overflowEvt) begin
      overflowFlag  <= 1'b1;
      overflowArmed <= 1'b0;
    end else if (writeDone && (paddr == `TPWM_ADDR_STATUS_CONTROL) && !pwdata[`TPWM_SC_OVF_FLAG] &&
                 overflowArmed && !flagProtect) begin
      overflowFlag  <= 1'b0;
      overflowArmed <= 1'b0;
    end else if (readDone && (paddr == `TPWM_ADDR_STATUS_CONTROL) && overflowFlag && !flagProtect) begin
      overflowArmed <= 1'b1;
    end
  end

  // Modulo register
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      modulo <= `TPWM_RST_MODULO;
    end else if (writeDone && (paddr == `TPWM_ADDR_MODULO)) begin
      modulo <= pwdata[WIDTH-1:0];
    end
  end

  // Channel control registers; flag bit lives in the channel module
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ch0Ctrl <= `TPWM_RST_CTRL;
      ch1Ctrl <= `TPWM_RST_CTRL;
    end else if (writeDone) begin
      if (paddr == `TPWM_ADDR_CH0_CONTROL) begin
        ch0Ctrl <= pwdata[6:0];
      end
      if (paddr == `TPWM_ADDR_CH1_CONTROL) begin
        ch1Ctrl <= {pwdata[`TPWM_CH_IE], 1'b0, pwdata[4:0]}; // Link bit exists only on channel 0
      end
    end
  end

  // Value registers: software writes, captures load the counter
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ch0Value <= `TPWM_RST_VALUE;
      ch1Value <= `TPWM_RST_VALUE;
    end else begin
      if (ch0Capture) begin
        ch0Value <= counter;
      end else if (writeDone && (paddr == `TPWM_ADDR_CH0_VALUE)) begin
        ch0Value <= pwdata[WIDTH-1:0];
      end
      if (ch1Capture) begin
        ch1Value <= counter;
      end else if (writeDone && (paddr == `TPWM_ADDR_CH1_VALUE)) begin
        ch1Value <= pwdata[WIDTH-1:0];
      end
    end
  end

  assign linkOn = ch0Ctrl[`TPWM_CH_LINK];

  // Linked value set hand-over: writes mark a set, overflow makes it active.
  // Writing the active set acts at once, which is unbuffered behaviour.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      activeSet   <= 1'b0;
      lastWritten <= 1'b0;
    end else if (!linkOn) begin
      activeSet   <= 1'b0; // channel 0 set first once linked
      lastWritten <= 1'b0;
    end else begin
      if (writeDone && (paddr == `TPWM_ADDR_CH1_VALUE)) begin
        lastWritten <= 1'b1;
      end else if (writeDone && (paddr == `TPWM_ADDR_CH0_VALUE)) begin
        lastWritten <= 1'b0;
      end
      if (overflowEvt) begin
        activeSet <= lastWritten;
      end
    end
  end

  assign ch0Compare = (linkOn && activeSet) ? ch1Value : ch0Value;

  // Pin synchronisers, two stages each
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ch0Sync <= 2'h0;
      ch1Sync <= 2'h0;
    end else begin
      ch0Sync <= {ch0Sync[0], channel0PinIn};
      ch1Sync <= {ch1Sync[0], channel1PinIn};
    end
  end

  // Flag strobes from the bus
  assign ch0ReadArm   = readDone && (paddr == `TPWM_ADDR_CH0_CONTROL);
  assign ch1ReadArm   = readDone && (paddr == `TPWM_ADDR_CH1_CONTROL);
  assign ch0WriteZero = writeDone && (paddr == `TPWM_ADDR_CH0_CONTROL) && !pwdata[`TPWM_CH_FLAG];
  assign ch1WriteZero = writeDone && (paddr == `TPWM_ADDR_CH1_CONTROL) && !pwdata[`TPWM_CH_FLAG];

  // Channel 0: link forces compare mode over the mode bit
  tpwm_channel #(
    .WIDTH (WIDTH)
  ) uChannel0 (
    .sysClk        (sys_clk),
    .rstN          (rst_n),
    .tick          (tick),
    .overflowEvt   (overflowEvt),
    .counter       (counter),
    .compareValue  (ch0Compare),
    .enable        (1'b1),
    .compareMode   (linkOn | ch0Ctrl[`TPWM_CH_MODE]),
    .edgeLevelSel  (ch0Ctrl[`TPWM_CH_ELS_HIGH:`TPWM_CH_ELS_LOW]),
    .toggleEn      (ch0Ctrl[`TPWM_CH_TOGGLE]),
    .fullDutyEn    (ch0Ctrl[`TPWM_CH_MAX]),
    .pinSync       (ch0Sync[1]),
    .captureAllow  (runEn),
    .flagReadArm   (ch0ReadArm),
    .flagWriteZero (ch0WriteZero),
    .flagProtect   (flagProtect),
    .flag          (ch0Flag),
    .pinOut        (channel0PinOut),
    .pinOe         (channel0PinOe),
    .captureStrobe (ch0Capture)
  );

  // Channel 1: idle and pin freed while linked
  tpwm_channel #(
    .WIDTH (WIDTH)
  ) uChannel1 (
    .sysClk        (sys_clk),
    .rstN          (rst_n),
    .tick          (tick),
    .overflowEvt   (overflowEvt),
    .counter       (counter),
    .compareValue  (ch1Value),
    .enable        (!linkOn),
    .compareMode   (ch1Ctrl[`TPWM_CH_MODE]),
    .edgeLevelSel  (ch1Ctrl[`TPWM_CH_ELS_HIGH:`TPWM_CH_ELS_LOW]),
    .toggleEn      (ch1Ctrl[`TPWM_CH_TOGGLE]),
    .fullDutyEn    (ch1Ctrl[`TPWM_CH_MAX]),
    .pinSync       (ch1Sync[1]),
    .captureAllow  (runEn),
    .flagReadArm   (ch1ReadArm),
    .flagWriteZero (ch1WriteZero),
    .flagProtect   (flagProtect),
    .flag          (ch1Flag),
    .pinOut        (channel1PinOut),
    .pinOe         (channel1PinOe),
    .captureStrobe (ch1Capture)
  );

  // Interrupt request; also wakes the processor from wait
  assign timerIrq = (overflowFlag && overflowIrqEn) ||
                    (ch0Flag && ch0Ctrl[`TPWM_CH_IE]) ||
                    (ch1Flag && ch1Ctrl[`TPWM_CH_IE] && !linkOn);

  // Read data and error are registered in the setup cycle.
  // Registers are closed to the processor during wait.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      pslverr <= !addrMapped || waitMode;
      prdata  <= 32'h00000000;
      if (!waitMode) begin
        case (paddr)
          `TPWM_ADDR_STATUS_CONTROL: prdata[7:0] <= {overflowFlag, overflowIrqEn, counterHalt, 1'b0,
                                                     1'b0, clockDivideSel};
          `TPWM_ADDR_COUNTER:        prdata[WIDTH-1:0] <= counter;
          `TPWM_ADDR_MODULO:         prdata[WIDTH-1:0] <= modulo;
          `TPWM_ADDR_CH0_CONTROL:    prdata[7:0] <= {ch0Flag, ch0Ctrl};
          `TPWM_ADDR_CH0_VALUE:      prdata[WIDTH-1:0] <= ch0Value;
          `TPWM_ADDR_CH1_CONTROL:    prdata[7:0] <= {ch1Flag, ch1Ctrl};
          `TPWM_ADDR_CH1_VALUE:      prdata[WIDTH-1:0] <= ch1Value;
          default:                   prdata <= 32'h00000000;
        endcase
      end
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

endmodule // tpwm_timer

// [tpwm_chk.sv]
// Port checker for the two-channel PWM timer
module tpwm_chk (
  input logic        sys_clk,
  input logic        rst_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        waitMode,
  input logic        breakState,
  input logic        breakClearEnable,
  input logic        channel0PinIn,
  input logic        channel1PinIn,
  input logic        channel0PinOut,
  input logic        channel0PinOe,
  input logic        channel1PinOut,
  input logic        channel1PinOe,
  input logic        timerIrq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] s;       // Status shadow
  logic [7:0] c0;      // Channel 0 control shadow
  logic [7:0] c1;      // Channel 1 control shadow
  logic       zeroCfg; // PWM without overflow toggle
  logic       fullCfg; // PWM with full duty
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Shadows follow only accepted writes, refused ones leave no trace
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s <= 8'h20; // Halt set out of reset
      c0 <= 8'h00;
      c1 <= 8'h00;
    end else if (psel && penable && pwrite && !pslverr) begin
      if (paddr == 8'h00) s <= pwdata[7:0];
      if (paddr == 8'h0C) c0 <= pwdata[7:0];
      if (paddr == 8'h14) c1 <= pwdata[7:0];
    end
  end
  assign zeroCfg = c0[4] && !c0[1] && c0[3:2] == 2'h2;
  assign fullCfg = c0[4] && c0[1:0] == 2'h3 && c0[3:2] == 2'h2;
  a_wait_refused: assert property (
    psel && !penable && waitMode |=> pslverr) else $error("wait access not refused");
  a_hole_refused: assert property (
    psel && !penable && paddr > 8'h18 |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_clear_reads0: assert property (
    psel && !penable && !pwrite && paddr == 8'h00 && !waitMode |=> !prdata[4] && prdata[6:5] == s[6:5] &&
    prdata[2:0] == s[2:0]) else $error("status read wrong");
  a_pin_owned: assert property (
    channel0PinOe == (c0[3:2] != 2'h0 && (c0[4] || c0[5]))) else $error("ch0 enable wrong");
  a_ch1_freed: assert property (c0[5] |-> !channel1PinOe) else $error("ch1 not freed");
  a_full_duty: assert property (
    fullCfg [*8] ##1 fullCfg |-> channel0PinOut) else $error("full duty low");
  a_zero_hold: assert property (
    zeroCfg && !channel0PinOut ##1 zeroCfg |-> !channel0PinOut) else $error("zero duty rose");
  a_irq_gated: assert property (
    !(s[6] || c0[6] || c1[6]) |-> !timerIrq) else $error("irq without enable");
endmodule // tpwm_chk

// [tpwm_pin_model.sv]
// Port side of the two shared channel pins
module tpwm_pin_model (
  input  logic channel0PinOut,
  input  logic channel0PinOe,
  input  logic channel1PinOut,
  input  logic channel1PinOe,
  input  logic extLevel0,     // Port drive level, channel 0
  input  logic extLevel1,     // Port drive level, channel 1
  output logic channel0PinIn,
  output logic channel1PinIn
);
  timeunit 1ns;
  timeprecision 100ps;
  // Timer drives while enabled, else the general-purpose port does
  assign channel0PinIn = channel0PinOe ? channel0PinOut : extLevel0;
  assign channel1PinIn = channel1PinOe ? channel1PinOut : extLevel1;
endmodule // tpwm_pin_model

// [tpwm_tb.sv]
// Self-checking testbench for the two-channel PWM timer
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv, n;
  logic        pready, pslverr, er, timerIrq, extLevel0 = 0, extLevel1 = 0;
  logic        waitMode = 0, breakState = 0, breakClearEnable = 0;
  logic        channel0PinIn, channel1PinIn, channel0PinOut, channel0PinOe, channel1PinOut, channel1PinOe;
  int          fail_count = 0, tests_run = 0, k;
  tpwm_timer     i_tpwm_timer (.*);
  tpwm_pin_model i_tpwm_pin_model (.*);
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (!pready);
    rv = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // High cycles of channel 0 over a window
  task automatic hi(input int c);
    k = 0;
    repeat (c) begin
      @(negedge sys_clk);
      k += (channel0PinIn === 1'b1) ? 1 : (channel0PinIn === 1'b0) ? 0 : 1000;
    end
  endtask
  task automatic t_reset;
    apb(0, 8'h00);
    chk("status", 32'h20, rv);
    apb(0, 8'h1C);
    chk("unmapped", 1, er);
    $display("test reset done");
  endtask
  task automatic t_ovf;
    apb(1, 8'h00, 32'h30);
    apb(0, 8'h04);
    chk("halt clear", 0, rv);
    apb(1, 8'h08, 32'h1);
    apb(1, 8'h00, 32'h00);
    repeat (20) @(posedge sys_clk);
    apb(0, 8'h00);
    chk("ovf flag", 1, rv[7]);
    apb(1, 8'h00, 32'h40);
    apb(0, 8'h00);
    chk("flag kept", 1, rv[7]);
    chk("irq", 1, timerIrq);
    apb(1, 8'h00, 32'h60);
    apb(0, 8'h00);
    apb(1, 8'h00, 32'h60);
    apb(0, 8'h04);
    n = rv;
    repeat (10) @(posedge sys_clk);
    apb(0, 8'h00);
    chk("flag cleared", 0, rv[7]);
    chk("irq off", 0, timerIrq);
    apb(0, 8'h04);
    chk("halted", n, rv);
    apb(1, 8'h00, 32'h30);
    apb(0, 8'h04);
    chk("clear", 0, rv);
    $display("test overflow done");
  endtask
  task automatic t_div;
    int e;
    apb(1, 8'h08, 32'hFFFF);
    for (int c = 0; c < 8; c++) begin
      apb(1, 8'h00, 32'h30 | c);
      apb(1, 8'h00, c);
      repeat (61) @(posedge sys_clk);
      apb(1, 8'h00, 32'h20 | c);
      apb(0, 8'h04);
      e = (c == 7) ? 0 : (64 >> c);
      chk("divide", e, rv);
    end
    $display("test prescaler done");
  endtask
  task automatic t_pwm;
    apb(1, 8'h00, 32'h30);
    apb(1, 8'h08, 32'h7);
    apb(1, 8'h10, 32'h3);
    apb(1, 8'h0C, 32'h1A);
    apb(1, 8'h00, 32'h00);
    repeat (16) @(posedge sys_clk);
    hi(32);
    chk("half duty", 16, k);
    apb(0, 8'h0C);
    chk("ch0 flag", 1, rv[7]);
    apb(1, 8'h0C, 32'h18);
    repeat (16) @(posedge sys_clk);
    hi(32);
    chk("zero duty", 0, k);
    apb(1, 8'h0C, 32'h1B);
    repeat (16) @(posedge sys_clk);
    hi(32);
    chk("full duty", 32, k);
    apb(1, 8'h0C, 32'h3A);
    apb(1, 8'h14, 32'h1A);
    apb(1, 8'h18, 32'h1);
    chk("ch1 freed", 0, channel1PinOe);
    repeat (24) @(posedge sys_clk);
    hi(32);
    chk("buffered", 8, k);
    $display("test pwm done");
  endtask
  task automatic t_cap;
    apb(1, 8'h00, 32'h30);
    apb(1, 8'h0C, 32'h00);
    apb(0, 8'h14);
    apb(1, 8'h14, 32'h04);
    extLevel1 <= 1;
    repeat (8) @(posedge sys_clk);
    apb(0, 8'h14);
    chk("halt no capture", 0, rv[7]);
    extLevel1 <= 0;
    apb(1, 8'h00, 32'h00);
    extLevel1 <= 1;
    repeat (8) @(posedge sys_clk);
    apb(0, 8'h14);
    chk("capture", 1, rv[7]);
    apb(1, 8'h14, 32'hC4);
    apb(0, 8'h14);
    chk("ch1 flag kept", 1, rv[7]);
    chk("ch1 irq", 1, timerIrq);
    apb(1, 8'h14, 32'h44);
    apb(0, 8'h14);
    chk("ch1 flag clear", 0, rv[7]);
    breakState <= 1;
    apb(0, 8'h04);
    n = rv;
    repeat (10) @(posedge sys_clk);
    apb(0, 8'h04);
    chk("break hold", n, rv);
    waitMode <= 1;
    apb(0, 8'h00);
    chk("wait refused", 1, er);
    waitMode <= 0;
    breakState <= 0;
    $display("test capture done");
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence after a four-cycle reset
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    t_reset;
    t_ovf;
    t_div;
    t_pwm;
    t_cap;
    close_out;
  end
  // Watchdog against a hung handshake
  initial begin
    #200000;
    fail_count++;
    close_out;
  end
endmodule // tb
bind tpwm_timer tpwm_chk i_tpwm_chk (.*);
